// *** design/pll_multiplier_select_low.sv ***
`timescale 1ns/1ps
module pll_multiplier_select_low
  import pll_mul_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic pll_on,
  output logic [15:0] feedback_divider
);
  logic [7:0] multiplier_low_bits_r, multiplier_low_bits_nxt;
  logic pll_on_bit_r, pll_on_bit_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [15:0] div_r, div_nxt;
  logic access;
  logic [15:0] combined;

  assign access = wb_req.cyc && wb_req.stb && !ack_r;
  assign combined = {multiplier_high_value, multiplier_low_bits_r};

  always_comb
  begin
    multiplier_low_bits_nxt = multiplier_low_bits_r;
    pll_on_bit_nxt = pll_on_bit_r;
    ack_nxt = access;
    dat_nxt = 32'h0000_0000;
    // divider mirrors the latest stored multiplier; zero behaves as one
    div_nxt = (combined == 16'h0000) ? 16'h0001 : combined;
    if (access && wb_req.we && wb_req.sel[0])
    begin
      // protection uses the pll-on state before this write lands
      if (wb_req.adr == addr_multiplier_low && !pll_on_bit_r)
      begin
        multiplier_low_bits_nxt = wb_req.dat[7:0];
      end
      if (wb_req.adr == addr_control)
      begin
        pll_on_bit_nxt = wb_req.dat[pll_on_pos];
      end
    end
    if (access && !wb_req.we)
    begin
      unique case (wb_req.adr)
        addr_multiplier_low: dat_nxt = {24'h000000, multiplier_low_bits_r};
        addr_control: dat_nxt = {31'h00000000, pll_on_bit_r};
        addr_multiplier_high: dat_nxt = {24'h000000, multiplier_high_value};
        addr_divider: dat_nxt = {16'h0000, div_r};
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      multiplier_low_bits_r <= multiplier_low_reset;
      pll_on_bit_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      div_r <= {multiplier_high_value, multiplier_low_reset};
    end
    else
    begin
      multiplier_low_bits_r <= multiplier_low_bits_nxt;
      pll_on_bit_r <= pll_on_bit_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      div_r <= div_nxt;
    end
  end

  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  assign pll_on = pll_on_bit_r;
  assign feedback_divider = div_r;

  property p_locked_hold;
    @(posedge clock) disable iff (sys_rst)
      pll_on_bit_r |=> multiplier_low_bits_r == $past(multiplier_low_bits_r);
  endproperty
  a_locked_hold: assert property (p_locked_hold)
    else $error("low byte changed while pll on");

  property p_write_lands;
    @(posedge clock) disable iff (sys_rst)
      access && wb_req.we && wb_req.sel[0] && wb_req.adr == addr_multiplier_low && !pll_on_bit_r
      |=> multiplier_low_bits_r == $past(wb_req.dat[7:0]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write not stored");

  property p_zero_is_one;
    @(posedge clock) disable iff (sys_rst)
      combined == 16'h0000 |=> div_r == 16'h0001;
  endproperty
  a_zero_is_one: assert property (p_zero_is_one) else $error("zero not mapped to one");

  property p_div_follows;
    @(posedge clock) disable iff (sys_rst)
      combined != 16'h0000 |=> div_r == $past(combined);
  endproperty
  a_div_follows: assert property (p_div_follows) else $error("divider wrong");

  property p_reset_value;
    @(posedge clock) $past(sys_rst) |-> multiplier_low_bits_r == 8'h40;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad reset value");

  property p_read_value;
    @(posedge clock) disable iff (sys_rst)
      access && !wb_req.we && wb_req.adr == addr_multiplier_low
      |=> wb_ack_o && wb_dat_o[7:0] == $past(multiplier_low_bits_r) && wb_dat_o[31:8] == 24'h0;
  endproperty
  a_read_value: assert property (p_read_value) else $error("read wrong");

  property p_read_no_effect;
    @(posedge clock) disable iff (sys_rst)
      access && !wb_req.we |=> multiplier_low_bits_r == $past(multiplier_low_bits_r);
  endproperty
  a_read_no_effect: assert property (p_read_no_effect)
    else $error("read disturbed value");

  property p_ack_once;
    @(posedge clock) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  // every taken request gets its answer one cycle later, and nothing else does
  property p_ack_follows;
    @(posedge clock) disable iff (sys_rst)
      access |=> wb_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("ack missing after request");

  property p_ack_needs_request;
    @(posedge clock) disable iff (sys_rst)
      !access |=> !wb_ack_o;
  endproperty
  a_ack_needs_request: assert property (p_ack_needs_request)
    else $error("ack without request");

  // read data is zero outside the answer so a late sample cannot see stale bytes
  property p_data_idle_zero;
    @(posedge clock) disable iff (sys_rst)
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_data_idle_zero: assert property (p_data_idle_zero)
    else $error("read data not zero while idle");

  property p_control_write;
    @(posedge clock) disable iff (sys_rst)
      access && wb_req.we && wb_req.sel[0] && wb_req.adr == addr_control
      |=> pll_on == $past(wb_req.dat[pll_on_pos]);
  endproperty
  a_control_write: assert property (p_control_write)
    else $error("pll on bit not written");

  property p_lane_gate;
    @(posedge clock) disable iff (sys_rst)
      access && wb_req.we && !wb_req.sel[0]
      |=> multiplier_low_bits_r == $past(multiplier_low_bits_r);
  endproperty
  a_lane_gate: assert property (p_lane_gate)
    else $error("write without low lane changed value");

  // the same-cycle pll-on state decides; a write racing the enable is dropped
  property p_locked_write_dropped;
    @(posedge clock) disable iff (sys_rst)
      access && wb_req.we && wb_req.adr == addr_multiplier_low && pll_on_bit_r
      |=> multiplier_low_bits_r == $past(multiplier_low_bits_r);
  endproperty
  a_locked_write_dropped: assert property (p_locked_write_dropped)
    else $error("write landed while pll on");

  property p_other_addr_keeps;
    @(posedge clock) disable iff (sys_rst)
      access && wb_req.we && wb_req.adr != addr_multiplier_low
      |=> multiplier_low_bits_r == $past(multiplier_low_bits_r);
  endproperty
  a_other_addr_keeps: assert property (p_other_addr_keeps)
    else $error("foreign write changed value");

  property p_control_read;
    @(posedge clock) disable iff (sys_rst)
      access && !wb_req.we && wb_req.adr == addr_control
      |=> wb_dat_o[0] == $past(pll_on_bit_r) && wb_dat_o[31:1] == 31'h0000_0000;
  endproperty
  a_control_read: assert property (p_control_read)
    else $error("control read wrong");

  property p_divider_read;
    @(posedge clock) disable iff (sys_rst)
      access && !wb_req.we && wb_req.adr == addr_divider
      |=> wb_dat_o == {16'h0000, $past(div_r)};
  endproperty
  a_divider_read: assert property (p_divider_read)
    else $error("divider read wrong");

  // the high byte is not built here, so it always reads as its fixed value
  property p_high_read;
    @(posedge clock) disable iff (sys_rst)
      access && !wb_req.we && wb_req.adr == addr_multiplier_high
      |=> wb_dat_o == {24'h000000, multiplier_high_value};
  endproperty
  a_high_read: assert property (p_high_read)
    else $error("high byte read wrong");

  property p_unmapped_read;
    @(posedge clock) disable iff (sys_rst)
      access && !wb_req.we && wb_req.adr != addr_multiplier_low && wb_req.adr != addr_control
      && wb_req.adr != addr_multiplier_high && wb_req.adr != addr_divider
      |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  // a zero divider would stall the loop, so it must never reach the pins
  property p_div_nonzero;
    @(posedge clock) disable iff (sys_rst)
      div_r != 16'h0000;
  endproperty
  a_div_nonzero: assert property (p_div_nonzero)
    else $error("divider shows zero");

  property p_reset_state;
    @(posedge clock)
      $past(sys_rst) |-> !pll_on_bit_r && !wb_ack_o
      && div_r == {multiplier_high_value, multiplier_low_reset};
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("bad state after reset");
endmodule : pll_multiplier_select_low

// *** inc/pll_mul_pkg.sv ***
// What this block does
// - An 8-bit read/write register holds the low byte of the PLL feedback divider multiplier.
// - Writes to the multiplier low byte are ignored while the PLL-on bit is 1.
// - A combined multiplier value of zero drives the divider exactly as a value of one.
// - Reset loads the multiplier low byte with 8'h40, a multiply value of 64.
package pll_mul_pkg;
  localparam logic [3:0] addr_multiplier_low = 4'h0;
  localparam logic [3:0] addr_control = 4'h4;
  localparam logic [3:0] addr_multiplier_high = 4'h8;
  localparam logic [3:0] addr_divider = 4'hc;
  localparam int pll_on_pos = 0;
  localparam logic [7:0] multiplier_low_reset = 8'h40;
  localparam logic [7:0] multiplier_high_value = 8'h00;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
endpackage : pll_mul_pkg

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import pll_mul_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  wb_req_t wb_req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic pll_on;
  logic [15:0] feedback_divider;
  logic [31:0] q;
  logic [3:0] lane = 4'hf;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  pll_multiplier_select_low pll_multiplier_select_low_inst (.clock(clock), .sys_rst(sys_rst),
    .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pll_on(pll_on),
    .feedback_divider(feedback_divider));
  always #2 clock = ~clock;
  task automatic end_of_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // a whole run needs well under a few hundred cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    if (seen !== exp)
      num_errors++;
  endtask : check
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    wb_req <= {1'b1, 1'b1, we, a, lane, d};
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_req <= '0;
    @(posedge clock);
    // the answer stands one cycle and read data falls back to zero
    check({31'h0, wb_ack_o}, 32'h0);
    check(wb_dat_o, 32'h0);
  endtask : wb
  task automatic t_reset;
    wb(1'b0, addr_multiplier_low, 32'h0);
    check(q, 32'h40);
    check({16'h0, feedback_divider}, 32'h40);
    wb(1'b0, addr_multiplier_high, 32'h0);
    check(q, {24'h000000, multiplier_high_value});
    wb(1'b0, addr_control, 32'h0);
    check(q, 32'h0);
  endtask : t_reset
  task automatic t_zero;
    wb(1'b1, addr_multiplier_low, 32'h0);
    wb(1'b0, addr_multiplier_low, 32'h0);
    check(q, 32'h0);
    check({16'h0, feedback_divider}, 32'h1);
    wb(1'b0, addr_divider, 32'h0);
    check(q, 32'h1);
  endtask : t_zero
  task automatic t_lock;
    // program the multiplier before the loop is switched on
    wb(1'b1, addr_multiplier_low, 32'h5a);
    wb(1'b1, addr_control, 32'h1);
    check({31'h0, pll_on}, 32'h1);
    wb(1'b0, addr_control, 32'h0);
    check(q, 32'h1);
    wb(1'b1, addr_multiplier_low, 32'ha5);
    wb(1'b0, addr_multiplier_low, 32'h0);
    check(q, 32'h5a);
    check({16'h0, feedback_divider}, 32'h5a);
    wb(1'b1, addr_control, 32'h0);
    wb(1'b1, addr_multiplier_low, 32'ha5);
    wb(1'b0, addr_multiplier_low, 32'h0);
    check(q, 32'ha5);
    wb(1'b0, 4'h2, 32'h0);
    check(q, 32'h0);
  endtask : t_lock
  task automatic t_lanes;
    wb(1'b1, addr_multiplier_low, 32'h33);
    // a write without the low byte lane must leave the multiplier alone
    lane = 4'he;
    wb(1'b1, addr_multiplier_low, 32'hcc);
    lane = 4'hf;
    wb(1'b0, addr_multiplier_low, 32'h0);
    check(q, 32'h33);
  endtask : t_lanes
  task automatic t_rerun;
    wb(1'b1, addr_multiplier_low, 32'h12);
    wb(1'b1, addr_control, 32'h1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    check({31'h0, pll_on}, 32'h0);
    check({16'h0, feedback_divider}, 32'h40);
    wb(1'b0, addr_multiplier_low, 32'h0);
    check(q, 32'h40);
  endtask : t_rerun
  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_zero();
    t_lock();
    t_lanes();
    t_rerun();
    end_of_test();
  end
endmodule : testbench
